// ---- src/ftr_regs_defs.svh ----
`ifndef FTR_REGS_DEFS_SVH
`define FTR_REGS_DEFS_SVH

// Register offsets
`define FTR_X_HIGH_OFS    8'h00
`define FTR_X_MID_OFS     8'h01
`define FTR_Y_HIGH_OFS    8'h02
`define FTR_Y_MID_OFS     8'h03
`define FTR_Z_HIGH_OFS    8'h04
`define FTR_Z_MID_OFS     8'h05
`define FTR_X_LOW_OFS     8'h06
`define FTR_Y_LOW_OFS     8'h07
`define FTR_Z_LOW_OFS     8'h08
`define FTR_TEMP_OFS      8'h09
`define FTR_FLAGS_OFS     8'h18
`define FTR_CTRL0_OFS     8'h1b

// Device flags fields
`define FTR_FLG_T_DONE    7
`define FTR_FLG_M_DONE    6
`define FTR_FLG_SELFTEST  5
`define FTR_FLG_TRIM_DONE 4
`define FTR_FLG_RSVD_MSB  3

// Trigger bits of control register 0
`define FTR_CTL_TRIG_M    0
`define FTR_CTL_TRIG_T    1

// Reset values
`define FTR_FLAGS_RST     8'h00
`define FTR_RESULT_RST    20'h00000
`define FTR_BYTE_RST      8'h00

// Result width and masks per resolution
`define FTR_RES_W         20
`define FTR_MASK_16       20'hffff0
`define FTR_MASK_18       20'hffffc
`define FTR_MASK_20       20'hfffff

`endif

// ---- src/ftr_pkg.sv ----
package ftr_pkg;
   // Resolution setting of the field converter
   typedef enum logic [1:0] {
      FTR_RES16 = 2'b00,
      FTR_RES18 = 2'b01,
      FTR_RES20 = 2'b10
   } ftr_res_t;

   // Field measurement trigger state
   typedef enum logic [1:0] {
      FTR_IDLE = 2'b01,
      FTR_BUSY = 2'b10
   } ftr_state_t;
endpackage : ftr_pkg

// ---- src/ftr_axis_hold.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ftr_regs_defs.svh"

module ftr_axis_hold
   import ftr_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       load,
   input  wire logic [19:0] sample,
   input  wire ftr_res_t   res_mode,
   output logic      [7:0] res_high,
   output logic      [7:0] res_mid,
   output logic      [7:0] res_low
);
   logic [19:0] value;
   logic [19:0] next_value;
   logic [19:0] mask;

   // Mask bits not meaningful at the chosen resolution; unsigned, no sign
   always_comb begin
      case (res_mode)
         FTR_RES16: mask = `FTR_MASK_16;
         FTR_RES18: mask = `FTR_MASK_18;
         FTR_RES20: mask = `FTR_MASK_20;
         default:   mask = `FTR_MASK_20;
      endcase
      next_value = load ? (sample & mask) : value;
   end

   // Result holder
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         value <= `FTR_RESULT_RST;
      end else begin
         value <= next_value;
      end
   end

   // Byte split, low nibble of the low byte always zero
   assign res_high = value[19:12];
   assign res_mid  = value[11:4];
   assign res_low  = {value[3:0], 4'h0};
endmodule : ftr_axis_hold
`default_nettype wire

// ---- src/ftr_result_regs.sv ----
// Functional notes
// - Axis results are 20 bits; 16/18-bit settings use only the upper bits.
// - Axis results are plain unsigned binary, no sign.
// - Temperature is 8-bit unsigned, code zero is minus 75 degrees.
// - Field done flag sets when a field measurement finishes.
// - Field done flag clears only on a read of an axis register.
// - Temperature done flag sets on finish, clears only on temperature read.
// - Trim done flag sets after trim memory load at power-up or reload.
// - Self-test flag follows self-test outcome, low once passed.
// - Four low status bits are factory bits reading zero.
// - Host writes one to trigger bit; device clears it when done.
`timescale 1ns/100ps
`default_nettype none
`include "ftr_regs_defs.svh"

module ftr_result_regs
   import ftr_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       rd_en,
   input  wire logic [7:0] rd_addr,
   output logic      [7:0] rd_data,
   output logic            rd_valid,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_addr,
   input  wire logic [7:0] wr_data,
   input  wire ftr_res_t   res_mode,
   input  wire logic       field_done,
   input  wire logic [19:0] x_sample,
   input  wire logic [19:0] y_sample,
   input  wire logic [19:0] z_sample,
   input  wire logic       temp_done,
   input  wire logic [7:0] temp_sample,
   input  wire logic       trim_load_done,
   input  wire logic       trim_reload,
   input  wire logic       selftest_fail,
   output logic            field_start,
   output logic            temp_start
);
   logic [7:0] x_high, x_mid, x_low;
   logic [7:0] y_high, y_mid, y_low;
   logic [7:0] z_high, z_mid, z_low;
   logic [7:0] temp_result, next_temp_result;
   logic       flag_m, next_flag_m;
   logic       flag_t, next_flag_t;
   logic       flag_trim, next_flag_trim;
   logic       flag_self, next_flag_self;
   logic       rd_axis, rd_temp;
   logic [7:0] flags;
   logic [7:0] next_rd_data;
   logic [7:0] rd_addr_q;
   ftr_state_t state, next_state;
   logic       temp_trig, next_temp_trig;
   logic       wr_ctrl;

   // One holder per axis
   ftr_axis_hold u_x (.ref_clk(ref_clk), .rst_n(rst_n), .load(field_done),
      .sample(x_sample), .res_mode(res_mode), .res_high(x_high),
      .res_mid(x_mid), .res_low(x_low));
   ftr_axis_hold u_y (.ref_clk(ref_clk), .rst_n(rst_n), .load(field_done),
      .sample(y_sample), .res_mode(res_mode), .res_high(y_high),
      .res_mid(y_mid), .res_low(y_low));
   ftr_axis_hold u_z (.ref_clk(ref_clk), .rst_n(rst_n), .load(field_done),
      .sample(z_sample), .res_mode(res_mode), .res_high(z_high),
      .res_mid(z_mid), .res_low(z_low));

   // Read and control write decode
   assign rd_axis = rd_en && (rd_addr <= `FTR_Z_LOW_OFS);
   assign rd_temp = rd_en && (rd_addr == `FTR_TEMP_OFS);
   assign wr_ctrl = wr_en && (wr_addr == `FTR_CTRL0_OFS);

   // Status byte, factory bits tied low
   assign flags = {flag_t, flag_m, flag_self, flag_trim, 4'h0};

   // Flag, temperature and trigger next values; a set beats a clear, except in FTR_BUSY where field_done wins over a field trigger write
   always_comb begin
      next_flag_m    = field_done | (flag_m & ~rd_axis);
      next_flag_t    = temp_done | (flag_t & ~rd_temp);
      next_flag_trim = trim_load_done | (flag_trim & ~trim_reload);
      next_flag_self = selftest_fail;
      next_temp_result = temp_done ? temp_sample : temp_result;
      next_temp_trig = temp_trig;
      if (temp_done) begin
         next_temp_trig = 1'b0;
      end
      if (wr_ctrl && wr_data[`FTR_CTL_TRIG_T]) begin
         next_temp_trig = 1'b1;
      end
      next_state = state;
      case (state)
         FTR_IDLE: begin
            if (wr_ctrl && wr_data[`FTR_CTL_TRIG_M]) begin
               next_state = FTR_BUSY;
            end
         end
         FTR_BUSY: begin
            if (field_done) begin
               next_state = FTR_IDLE;
            end
         end
         default: next_state = FTR_IDLE;
      endcase
   end

   // Read mux; all other writes are dropped
   always_comb begin
      case (rd_addr)
         `FTR_X_HIGH_OFS: next_rd_data = x_high;
         `FTR_X_MID_OFS:  next_rd_data = x_mid;
         `FTR_Y_HIGH_OFS: next_rd_data = y_high;
         `FTR_Y_MID_OFS:  next_rd_data = y_mid;
         `FTR_Z_HIGH_OFS: next_rd_data = z_high;
         `FTR_Z_MID_OFS:  next_rd_data = z_mid;
         `FTR_X_LOW_OFS:  next_rd_data = x_low;
         `FTR_Y_LOW_OFS:  next_rd_data = y_low;
         `FTR_Z_LOW_OFS:  next_rd_data = z_low;
         `FTR_TEMP_OFS:   next_rd_data = temp_result;
         `FTR_FLAGS_OFS:  next_rd_data = flags;
         default:         next_rd_data = `FTR_BYTE_RST;
      endcase
      if (!rd_en) begin
         next_rd_data = rd_data;
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flag_m      <= 1'b0;
         flag_t      <= 1'b0;
         flag_trim   <= 1'b0;
         flag_self   <= 1'b0;
         temp_result <= `FTR_BYTE_RST;
         temp_trig   <= 1'b0;
         state       <= FTR_IDLE;
         rd_data     <= `FTR_BYTE_RST;
         rd_valid    <= 1'b0;
         rd_addr_q   <= `FTR_BYTE_RST;
      end else begin
         flag_m      <= next_flag_m;
         flag_t      <= next_flag_t;
         flag_trim   <= next_flag_trim;
         flag_self   <= next_flag_self;
         temp_result <= next_temp_result;
         temp_trig   <= next_temp_trig;
         state       <= next_state;
         rd_data     <= next_rd_data;
         rd_valid    <= rd_en;
         rd_addr_q   <= rd_addr;
      end
   end

   // Trigger levels toward the converters
   assign field_start = (state == FTR_BUSY);
   assign temp_start  = temp_trig;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_axis_read;
      rd_axis && !field_done;
   endsequence

   sequence s_temp_read;
      rd_temp && !temp_done;
   endsequence

   a_read_answer: assert property (rd_en |=> rd_valid)
      else $error("read not answered");
   a_low_nibble: assert property (
      rd_valid && rd_addr_q >= `FTR_X_LOW_OFS && rd_addr_q <= `FTR_Z_LOW_OFS
      |-> rd_data[3:0] == 4'h0)
      else $error("low nibble not zero");
   a_res_mask16: assert property (
      field_done && res_mode == FTR_RES16 |=> x_low == 8'h00)
      else $error("16-bit mask wrong");
   a_axis_value: assert property (
      field_done && res_mode == FTR_RES20
      |=> {y_high, y_mid, y_low[7:4]} == $past(y_sample))
      else $error("axis value wrong");
   a_temp_value: assert property (
      temp_done |=> temp_result == $past(temp_sample))
      else $error("temperature not held");
   a_mflag_set: assert property (field_done |=> flag_m)
      else $error("field flag not set");
   a_mflag_clear: assert property (s_axis_read |=> !flag_m)
      else $error("field flag not cleared");
   a_mflag_hold: assert property (
      flag_m && !rd_axis |=> flag_m)
      else $error("field flag lost");
   a_tflag_cycle: assert property (
      temp_done ##1 s_temp_read |=> !flag_t)
      else $error("temperature flag wrong");
   a_trim_set: assert property (trim_load_done |=> flags[4])
      else $error("trim flag not set");
   a_self_flag: assert property (
      !selftest_fail [*2] |-> !flags[`FTR_FLG_SELFTEST])
      else $error("self-test flag high after pass");
   a_rsvd_zero: assert property (flags[3:0] == 4'h0)
      else $error("factory bits not zero");
   a_rsvd_read: assert property (
      rd_valid && rd_addr_q == `FTR_FLAGS_OFS |-> rd_data[3:0] == 4'h0)
      else $error("factory bits read nonzero");
   a_trig_clear: assert property (
      field_start && field_done |=> !field_start)
      else $error("trigger not cleared");

   // Temperature flag checks on the normal read path, then trim reload and control write trigger checks
   a_tflag_set: assert property (temp_done |=> flag_t)
      else $error("temperature flag not set");
   a_tflag_clear: assert property (s_temp_read |=> !flag_t)
      else $error("temperature flag not cleared");
   a_trim_clear: assert property (
      trim_reload && !trim_load_done
      |=> !flags[`FTR_FLG_TRIM_DONE])
      else $error("trim flag not cleared on reload");
   a_field_trig: assert property (
      wr_ctrl && wr_data[`FTR_CTL_TRIG_M] && !field_start |=> field_start)
      else $error("field trigger not taken");
   a_temp_trig: assert property (
      wr_ctrl && wr_data[`FTR_CTL_TRIG_T] |=> temp_start)
      else $error("temperature trigger not taken");
endmodule : ftr_result_regs
`default_nettype wire

// ---- test/ftr_meas_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module ftr_meas_model #(
   parameter int LAT = 5
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        field_start,
   input  wire logic        temp_start,
   input  wire logic [19:0] x_val,
   input  wire logic [19:0] y_val,
   input  wire logic [19:0] z_val,
   input  wire logic [7:0]  t_val,
   output logic             field_done,
   output logic             temp_done,
   output logic      [19:0] x_sample,
   output logic      [19:0] y_sample,
   output logic      [19:0] z_sample,
   output logic      [7:0]  temp_sample
);
   logic [7:0] fc;
   logic [7:0] tc;

   // One done pulse LAT+1 cycles after each request
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fc         <= 8'h00;
         tc         <= 8'h00;
         field_done <= 1'b0;
         temp_done  <= 1'b0;
      end else begin
         field_done <= field_start && !field_done && fc == 8'(LAT);
         temp_done  <= temp_start && !temp_done && tc == 8'(LAT);
         fc <= (field_start && !field_done && fc != 8'(LAT)) ?
               fc + 8'h01 : 8'h00;
         tc <= (temp_start && !temp_done && tc != 8'(LAT)) ?
               tc + 8'h01 : 8'h00;
      end
   end

   // Samples are only valid in the done cycle; inverted otherwise
   assign x_sample    = field_done ? x_val : ~x_val;
   assign y_sample    = field_done ? y_val : ~y_val;
   assign z_sample    = field_done ? z_val : ~z_val;
   assign temp_sample = temp_done ? t_val : ~t_val;
endmodule : ftr_meas_model

`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb
   import ftr_pkg::*;
;
   logic        ref_clk, rst_n, rd_en, wr_en, rd_valid;
   logic        field_done, temp_done, trim_load_done, trim_reload;
   logic        selftest_fail, field_start, temp_start;
   logic [7:0]  rd_addr, rd_data, wr_addr, wr_data, temp_sample, t_val;
   logic [19:0] x_sample, y_sample, z_sample, mask, e;
   logic [19:0] vals [3];
   ftr_res_t    res_mode;
   int          err_count, n_checks;

   ftr_result_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .rd_en(rd_en),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .res_mode(res_mode), .field_done(field_done), .x_sample(x_sample),
      .y_sample(y_sample), .z_sample(z_sample), .temp_done(temp_done),
      .temp_sample(temp_sample), .trim_load_done(trim_load_done),
      .trim_reload(trim_reload), .selftest_fail(selftest_fail),
      .field_start(field_start), .temp_start(temp_start));

   ftr_meas_model pm (.ref_clk(ref_clk), .rst_n(rst_n),
      .field_start(field_start), .temp_start(temp_start), .x_val(vals[0]),
      .y_val(vals[1]), .z_val(vals[2]), .t_val(t_val),
      .field_done(field_done), .temp_done(temp_done), .x_sample(x_sample),
      .y_sample(y_sample), .z_sample(z_sample), .temp_sample(temp_sample));

   // Clock generator
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Register read: strobe one cycle, data checked just after the edge that takes it
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      rd_en   <= 1'b1;
      rd_addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      chk({19'h0, rd_valid}, 20'h1);
      chk({12'h0, rd_data}, {12'h0, exp});
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_en   <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : wr

   // Trigger a measurement and wait for the trigger to drop
   task automatic meas(input logic [7:0] d);
      wr(8'h1b, d);
      #1;
      chk({18'h0, temp_start, field_start}, {18'h0, d[1:0]});
      for (int k = 0; k < 40 && (field_start | temp_start) !== 1'b0; k++) begin
         @(posedge ref_clk);
         #1;
      end
      chk({18'h0, temp_start, field_start}, 20'h0);
   endtask : meas

   // Watchdog
   initial begin
      #20000;
      err_count++;
      close_out();
   end

   // Main sequence
   initial begin
      {rst_n, rd_en, wr_en, trim_load_done, trim_reload, selftest_fail} = '0;
      {rd_addr, wr_addr, wr_data, t_val} = '0;
      res_mode = FTR_RES16;
      vals = '{20'hfedcb, 20'h9a57f, 20'h1234e};
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h18, 8'h00);
      wr(8'h00, 8'hff);
      wr(8'h18, 8'hff);
      rd(8'h00, 8'h00);
      rd(8'h18, 8'h00);
      $display("test reset_writes done");
      for (int m = 0; m < 4; m++) begin
         @(posedge ref_clk);
         res_mode <= ftr_res_t'(2'(m));
         mask = (m == 0) ? 20'hffff0 : (m == 1) ? 20'hffffc : 20'hfffff;
         meas(8'h01);
         rd(8'h18, 8'h40);
         rd(8'h09, 8'h00);
         rd(8'h18, 8'h40);
         for (int i = 0; i < 3; i++) begin
            e = vals[i] & mask;
            rd(8'(2 * i), e[19:12]);
            rd(8'(2 * i + 1), e[11:4]);
            rd(8'(6 + i), {e[3:0], 4'h0});
         end
         rd(8'h18, 8'h00);
      end
      $display("test field done");
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         t_val <= (k == 0) ? 8'h00 : 8'hff;
         meas(8'h02);
         rd(8'h18, 8'h80);
         rd(8'h00, 8'hfe);
         rd(8'h18, 8'h80);
         rd(8'h09, (k == 0) ? 8'h00 : 8'hff);
         rd(8'h18, 8'h00);
      end
      $display("test temperature done");
      @(posedge ref_clk);
      trim_load_done <= 1'b1;
      selftest_fail  <= 1'b1;
      @(posedge ref_clk);
      trim_load_done <= 1'b0;
      rd(8'h18, 8'h30);
      @(posedge ref_clk);
      trim_reload   <= 1'b1;
      selftest_fail <= 1'b0;
      @(posedge ref_clk);
      trim_reload <= 1'b0;
      rd(8'h18, 8'h00);
      @(posedge ref_clk);
      trim_load_done <= 1'b1;
      @(posedge ref_clk);
      trim_load_done <= 1'b0;
      rd(8'h18, 8'h10);
      $display("test trim_selftest done");
      close_out();
   end
endmodule : tb

`default_nettype wire
